// ==== fep_rx_pcs_decode.v ====
// Functional notes
// R1: signal detect ignores short link pulses; needs a sustained detect level.
// R2: lock to line clock edges, give bit strobe and recovered clock.
// R3: nrzi to nrz, then descrambler, alignment, or raw bypass.
// R4: deserialise bits into 5-bit symbols for the receive state machine.
// R5: unscrambled bit is scrambled bit xor regenerated key bit.
// R6: sync declared after 12 consecutive idle groups of all ones.
// R7: hold timer 722 us restarted by 58 idle bit times.
// R8: hold timer expiry drops sync and resets the descrambler.
// R9: search j then k, then frame 5-bit groups on that boundary.
// R10: j/k after idles becomes two preamble nibbles 0101 0101.
// R11: decode groups to nibbles until t/r or two idles.
// R12: link up only after signal detect valid 395 us continuously.
// R13: bad start of stream gives rx_er and 1110 per group.
// R14: each bad start of stream adds one to false carrier counter.
// R15: two idles after bad start end rx_er and crs.
// R16: key from closed loop 11-bit lfsr like the scrambler.
// R17: standard 4b/5b table; idle carries nibble 0000.
// R18: halt 00100 and unused patterns are invalid groups.
// R19: halt or invalid group in a packet raises rx_er for that nibble.
`timescale 1ns/10ps
`include "fep_rx_defines.vh"
module fep_rx_pcs_decode #(
	parameter [16:0] LINK_UP_CYCLES = `FEP_LINK_UP_CYC,
	parameter [16:0] HOLD_CYCLES = `FEP_HOLD_CYC,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire ref_clk_i,
	input wire reset_i,
	// line side
	input wire line_clk_i,
	input wire line_data_i,
	input wire signal_detect_i,
	// configuration
	input wire desc_bypass_i,
	input wire rx_bypass_i,
	// status
	output reg rec_clk_o,
	output wire sd_valid_o,
	output reg link_up_o,
	output wire pcs_enable_o,
	output reg desc_sync_o,
	output reg [CNT_W-1:0] false_carrier_event_counter_o,
	// symbols
	output reg [4:0] sym_o,
	output reg sym_valid_o,
	// mii receive
	output reg [3:0] rxd_o,
	output reg rx_dv_o,
	output reg rx_er_o,
	output reg crs_o,
	output reg nibble_valid_o
);
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_CAND = 4'h2;
	localparam [3:0] ST_DATA = 4'h4;
	localparam [3:0] ST_BAD = 4'h8;
	localparam [6:0] SD_QUAL = `FEP_SD_QUAL_CYC;

	wire lclk_s;
	wire ldata_s;
	wire sd_s;
	reg lclk_d;
	reg prev_line;
	reg [6:0] sd_cnt;
	reg [16:0] link_cnt;
	reg [10:0] lfsr;
	reg [6:0] run;
	reg [6:0] idle_bits;
	reg [16:0] hold_cnt;
	reg [8:0] sh;
	reg [3:0] ones_run;
	reg [3:0] cand_cnt;
	reg [2:0] bit_cnt;
	reg [2:0] byp_cnt;
	reg [3:0] state;
	reg idle_cnt;
	reg t_seen;
	reg pre_pend;

	// 4b/5b lookup: {error, nibble}
	function [4:0] dec45;
		input [4:0] cg;
		begin
			case (cg)
				5'h1E: dec45 = 5'h00;
				5'h09: dec45 = 5'h01;
				5'h14: dec45 = 5'h02;
				5'h15: dec45 = 5'h03;
				5'h0A: dec45 = 5'h04;
				5'h0B: dec45 = 5'h05;
				5'h0E: dec45 = 5'h06;
				5'h0F: dec45 = 5'h07;
				5'h12: dec45 = 5'h08;
				5'h13: dec45 = 5'h09;
				5'h16: dec45 = 5'h0A;
				5'h17: dec45 = 5'h0B;
				5'h1A: dec45 = 5'h0C;
				5'h1B: dec45 = 5'h0D;
				5'h1C: dec45 = 5'h0E;
				5'h1D: dec45 = 5'h0F;
				`FEP_CG_IDLE: dec45 = 5'h00;
				default: dec45 = 5'h10;
			endcase
		end
	endfunction

	fep_sync2 #(.WIDTH(3)) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.async_i({line_clk_i, line_data_i, signal_detect_i}),
		.sync_o({lclk_s, ldata_s, sd_s})
	);

	// the line clock is oversampled only 8x in the bench, so one edge per bit is the whole recovery
	wire bit_stb = lclk_s & ~lclk_d; // [R2]
	wire nrz = ldata_s ^ prev_line; // [R3]
	wire key = lfsr[10] ^ lfsr[8]; // [R16]
	wire ud = nrz ^ key; // [R5]
	wire sbit = desc_bypass_i ? nrz : ud; // [R3]
	wire stream_ok = link_up_o & (desc_bypass_i | desc_sync_o) & ~rx_bypass_i;
	wire [9:0] win = {sh, sbit};
	wire [4:0] grp = win[4:0];
	wire [4:0] dec = dec45(grp); // [R17] [R18]
	wire grp_end = (bit_cnt == `FEP_GRP_LAST);
	wire [4:0] byp_sym = {sh[3:0], nrz};

	assign sd_valid_o = (sd_cnt == SD_QUAL);
	assign pcs_enable_o = link_up_o; // [R12]

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			lclk_d <= 1'b0;
			rec_clk_o <= 1'b0;
			prev_line <= 1'b0;
		end else begin
			lclk_d <= lclk_s;
			rec_clk_o <= lclk_s; // [R2]
			if (bit_stb)
				prev_line <= ldata_s;
		end
	end

	// link pulses last about 100 ns, far below the qualification time
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			sd_cnt <= 7'h00;
			link_cnt <= 17'h00000;
			link_up_o <= 1'b0;
		end else begin
			if (!sd_s)
				sd_cnt <= 7'h00; // [R1]
			else if (sd_cnt != SD_QUAL)
				sd_cnt <= sd_cnt + 7'h01; // [R1]
			if (!sd_valid_o) begin
				link_cnt <= 17'h00000;
				link_up_o <= 1'b0; // [R12]
			end else if (link_cnt == LINK_UP_CYCLES - 17'h00001) begin
				link_up_o <= 1'b1; // [R12]
			end else begin
				link_cnt <= link_cnt + 17'h00001; // [R12]
			end
		end
	end

	// descrambler: open loop while hunting, closed loop once in sync
	always @(posedge ref_clk_i) begin
		if (reset_i || !link_up_o || desc_bypass_i) begin
			lfsr <= 11'h000;
			run <= 7'h00;
			idle_bits <= 7'h00;
			hold_cnt <= 17'h00000;
			desc_sync_o <= 1'b0;
		end else if (!desc_sync_o) begin
			if (bit_stb) begin
				lfsr <= {lfsr[9:0], ~nrz};
				if (nrz == key) begin
					run <= 7'h00;
				end else if (run == `FEP_SYNC_BITS - 7'h01) begin
					desc_sync_o <= 1'b1; // [R6]
					hold_cnt <= 17'h00000; // [R7]
					idle_bits <= 7'h00;
				end else begin
					run <= run + 7'h01; // [R6]
				end
			end
		end else begin
			// idle count wraps so a long idle restarts the timer every 58 bits
			if (bit_stb) begin
				lfsr <= {lfsr[9:0], key}; // [R16]
				if (!ud || idle_bits == `FEP_HOLD_IDLE_BITS - 7'h01)
					idle_bits <= 7'h00;
				else
					idle_bits <= idle_bits + 7'h01; // [R7]
			end
			// a restart in the expiry cycle keeps sync; expiry clears the key after the shift above
			if (bit_stb && ud && idle_bits == `FEP_HOLD_IDLE_BITS - 7'h01) begin
				hold_cnt <= 17'h00000; // [R7]
			end else if (hold_cnt == HOLD_CYCLES - 17'h00001) begin
				desc_sync_o <= 1'b0; // [R8]
				lfsr <= 11'h000; // [R8]
				run <= 7'h00;
			end else begin
				hold_cnt <= hold_cnt + 17'h00001; // [R7]
			end
		end
	end

	// raw symbols on a free-running boundary when the whole receiver is bypassed
	always @(posedge ref_clk_i) begin
		if (reset_i || !rx_bypass_i)
			byp_cnt <= 3'h0;
		else if (bit_stb)
			byp_cnt <= (byp_cnt == `FEP_GRP_LAST) ? 3'h0 : byp_cnt + 3'h1; // [R4]
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			sh <= 9'h000;
			ones_run <= 4'h0;
			cand_cnt <= 4'h0;
			bit_cnt <= 3'h0;
			idle_cnt <= 1'b0;
			t_seen <= 1'b0;
			pre_pend <= 1'b0;
			sym_o <= 5'h00;
			sym_valid_o <= 1'b0;
			rxd_o <= `FEP_NIB_ZERO;
			rx_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
			crs_o <= 1'b0;
			nibble_valid_o <= 1'b0;
			false_carrier_event_counter_o <= {CNT_W{1'b0}};
		end else begin
			sym_valid_o <= 1'b0;
			nibble_valid_o <= 1'b0;
			if (rx_bypass_i && bit_stb) begin
				sh <= {sh[7:0], nrz};
				if (byp_cnt == `FEP_GRP_LAST) begin
					sym_o <= byp_sym; // [R3] [R4]
					sym_valid_o <= 1'b1;
				end
			end
			if (!stream_ok) begin
				state <= ST_IDLE;
				ones_run <= 4'h0;
				rx_dv_o <= 1'b0;
				rx_er_o <= 1'b0;
				crs_o <= 1'b0;
			end else if (bit_stb) begin
				sh <= win[8:0];
				if (!sbit)
					ones_run <= 4'h0;
				else if (ones_run != `FEP_IDLE_RUN)
					ones_run <= ones_run + 4'h1;
				bit_cnt <= grp_end ? 3'h0 : bit_cnt + 3'h1;
				if ((state & (ST_DATA | ST_BAD)) != 4'h0 && grp_end) begin
					sym_o <= grp; // [R4] [R9]
					sym_valid_o <= 1'b1;
				end
				case (state)
					ST_IDLE: begin
						if (!sbit && ones_run == `FEP_IDLE_RUN) begin
							state <= ST_CAND;
							cand_cnt <= 4'h1;
						end
					end
					ST_CAND: begin
						cand_cnt <= cand_cnt + 4'h1;
						if (cand_cnt == `FEP_CAND_JK_BIT && win == `FEP_JK) begin
							state <= ST_DATA; // [R9]
							bit_cnt <= 3'h0; // [R9]
							idle_cnt <= 1'b0;
							t_seen <= 1'b0;
							pre_pend <= 1'b1;
							rxd_o <= `FEP_NIB_PREAMBLE; // [R10]
							rx_dv_o <= 1'b1;
							rx_er_o <= 1'b0;
							crs_o <= 1'b1;
							nibble_valid_o <= 1'b1;
						end else if (cand_cnt == `FEP_CAND_LAST) begin
							state <= ST_BAD; // [R13]
							bit_cnt <= 3'h0;
							idle_cnt <= 1'b0;
							rxd_o <= `FEP_NIB_BAD_SSD; // [R13]
							rx_dv_o <= 1'b0;
							rx_er_o <= 1'b1; // [R13]
							crs_o <= 1'b1;
							nibble_valid_o <= 1'b1;
							false_carrier_event_counter_o <= false_carrier_event_counter_o + 1'b1; // [R14]
						end
					end
					ST_DATA: begin
						if (pre_pend) begin
							pre_pend <= 1'b0;
							rxd_o <= `FEP_NIB_PREAMBLE; // [R10]
							nibble_valid_o <= 1'b1;
						end
						if (grp_end) begin
							if (grp == `FEP_CG_IDLE) begin
								idle_cnt <= 1'b1;
								t_seen <= 1'b0;
								if (idle_cnt) begin
									state <= ST_IDLE; // [R11]
									rx_dv_o <= 1'b0;
									rx_er_o <= 1'b0;
									crs_o <= 1'b0;
								end
							end else if (grp == `FEP_CG_T) begin
								t_seen <= 1'b1;
								idle_cnt <= 1'b0;
							end else if (grp == `FEP_CG_R && t_seen) begin
								state <= ST_IDLE; // [R11]
								rx_dv_o <= 1'b0;
								rx_er_o <= 1'b0;
								crs_o <= 1'b0;
							end else begin
								idle_cnt <= 1'b0;
								t_seen <= 1'b0;
								rxd_o <= dec[3:0]; // [R11] [R17]
								rx_er_o <= dec[4]; // [R18] [R19]
								nibble_valid_o <= 1'b1;
							end
						end
					end
					ST_BAD: begin
						if (grp_end) begin
							if (grp == `FEP_CG_IDLE) begin
								idle_cnt <= 1'b1;
								if (idle_cnt) begin
									state <= ST_IDLE;
									rx_er_o <= 1'b0; // [R15]
									crs_o <= 1'b0; // [R15]
								end
							end else begin
								idle_cnt <= 1'b0;
								rxd_o <= `FEP_NIB_BAD_SSD; // [R13]
								nibble_valid_o <= 1'b1;
							end
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule // fep_rx_pcs_decode

// ==== fep_rx_defines.vh ====
`ifndef FEP_RX_DEFINES_VH
`define FEP_RX_DEFINES_VH

// reference clock
`define FEP_CLK_PERIOD_NS 10

// timing, in ns as specified
`define FEP_SD_QUAL_NS 1000
`define FEP_LINK_UP_NS 395000
`define FEP_HOLD_NS 722000

// cycle counts at the 10 ns clock, sized to the counters that use them
`define FEP_SD_QUAL_CYC 7'h64
`define FEP_LINK_UP_CYC 17'h09A4C
`define FEP_HOLD_CYC 17'h11A08

// descrambler sync: 12 idle groups of 5 bits, hold restart after 58 idle bits
`define FEP_SYNC_BITS 7'h3C
`define FEP_HOLD_IDLE_BITS 7'h3A

// code-groups, first received bit in the msb
`define FEP_CG_IDLE 5'h1F
`define FEP_CG_J 5'h18
`define FEP_CG_K 5'h11
`define FEP_CG_T 5'h0D
`define FEP_CG_R 5'h07
`define FEP_CG_HALT 5'h04
`define FEP_JK 10'h311

// nibbles shown on the mii
`define FEP_NIB_PREAMBLE 4'h5
`define FEP_NIB_BAD_SSD 4'hE
`define FEP_NIB_ZERO 4'h0

// start-of-stream search
`define FEP_IDLE_RUN 4'hA
`define FEP_CAND_JK_BIT 4'h7
`define FEP_CAND_LAST 4'h9
`define FEP_GRP_LAST 3'h4

`endif

// ==== fep_sync2.v ====
`timescale 1ns/10ps
module fep_sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire ref_clk_i,
	input wire reset_i,
	// asynchronous side
	input wire [WIDTH-1:0] async_i,
	// synchronised side
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta;

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule // fep_sync2

// ==== fep_rx_pcs_monitor.sv ====
`timescale 1ns/10ps
module fep_rx_pcs_monitor #(
	parameter [16:0] LINK_UP_CYCLES = 17'h09A4C,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire ref_clk_i,
	input wire reset_i,
	// inputs
	input wire signal_detect_i,
	input wire desc_bypass_i,
	// outputs
	input wire sd_valid_o,
	input wire link_up_o,
	input wire pcs_enable_o,
	input wire desc_sync_o,
	input wire [CNT_W-1:0] false_carrier_event_counter_o,
	input wire sym_valid_o,
	input wire [3:0] rxd_o,
	input wire rx_dv_o,
	input wire rx_er_o,
	input wire crs_o,
	input wire nibble_valid_o
);
	reg [16:0] sd_run;
	reg [16:0] lk_run;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// run lengths saturate so a long link never wraps below the bound
	always @(posedge ref_clk_i) begin
		sd_run <= (reset_i || !signal_detect_i) ? 17'h00000 : sd_run + {16'h0000, ~&sd_run};
		lk_run <= (reset_i || !sd_valid_o) ? 17'h00000 : lk_run + {16'h0000, ~&lk_run};
	end
	chk_sd_qualify: assert property ($rose(sd_valid_o) |-> sd_run >= 17'h00062)
		else $error("signal detect qualified too soon");
	chk_link_early: assert property ($rose(link_up_o) |-> lk_run + 17'h00002 >= LINK_UP_CYCLES)
		else $error("link up too early");
	chk_link_late: assert property (lk_run == LINK_UP_CYCLES + 17'h00004 |-> link_up_o)
		else $error("link up missing");
	chk_link_drop: assert property (!sd_valid_o |=> !link_up_o)
		else $error("link held without detect");
	chk_pcs_enable: assert property (pcs_enable_o == link_up_o)
		else $error("pcs enable differs from link");
	chk_idle_forced: assert property (!link_up_o || !(desc_sync_o || desc_bypass_i) |=> !(rx_dv_o || crs_o || rx_er_o))
		else $error("receive not idle without sync");
	chk_preamble_nib: assert property ($rose(rx_dv_o) |-> nibble_valid_o && rxd_o == 4'h5 && crs_o && !rx_er_o)
		else $error("packet did not open with preamble");
	chk_bad_nibble: assert property (nibble_valid_o && rx_er_o && !rx_dv_o |-> rxd_o == 4'hE)
		else $error("false carrier nibble wrong");
	chk_fcc_step: assert property ($changed(false_carrier_event_counter_o) |->
		false_carrier_event_counter_o == $past(false_carrier_event_counter_o) + 1'b1 && rx_er_o && !rx_dv_o)
		else $error("false carrier count step wrong");
	chk_sym_pulse: assert property (sym_valid_o |=> !sym_valid_o)
		else $error("symbol strobe too long");
endmodule // fep_rx_pcs_monitor

bind fep_rx_pcs_decode fep_rx_pcs_monitor #(.LINK_UP_CYCLES(LINK_UP_CYCLES), .CNT_W(CNT_W)) u_mon (
	.ref_clk_i(ref_clk_i),
	.reset_i(reset_i),
	.signal_detect_i(signal_detect_i),
	.desc_bypass_i(desc_bypass_i),
	.sd_valid_o(sd_valid_o),
	.link_up_o(link_up_o),
	.pcs_enable_o(pcs_enable_o),
	.desc_sync_o(desc_sync_o),
	.false_carrier_event_counter_o(false_carrier_event_counter_o),
	.sym_valid_o(sym_valid_o),
	.rxd_o(rxd_o),
	.rx_dv_o(rx_dv_o),
	.rx_er_o(rx_er_o),
	.crs_o(crs_o),
	.nibble_valid_o(nibble_valid_o)
);

// ==== fep_far_line.sv ====
`timescale 1ns/10ps
module fep_far_line (
	// line
	output logic line_clk_o,
	output logic line_data_o,
	// control
	input wire scr_en_i
);
	logic [4:0] q[$];
	logic [10:0] lfsr = 11'h2A5;
	logic [4:0] g;
	logic key;
	// idle fills every gap, so the line clock never stops
	initial begin
		line_clk_o = 1'b0;
		line_data_o = 1'b0;
		#3;
		forever begin
			g = (q.size() != 0) ? q.pop_front() : 5'h1F;
			for (int i = 4; i >= 0; i--) begin
				key = lfsr[10] ^ lfsr[8];
				lfsr = {lfsr[9:0], key};
				line_data_o = line_data_o ^ g[i] ^ (key & scr_en_i);
				#40 line_clk_o = 1'b1;
				#40 line_clk_o = 1'b0;
			end
		end
	end
endmodule // fep_far_line

// ==== test_fast_eth_rx_pcs_decode.sv ====
`timescale 1ns/10ps
module test_fast_eth_rx_pcs_decode;
	logic ref_clk_i, reset_i, signal_detect_i, desc_bypass_i, rx_bypass_i, scr;
	wire line_clk, line_data, sd_valid, link_up, desc_sync, sym_valid;
	wire rx_dv, rx_er, crs, nib_valid, rec_clk;
	logic rc_prev;
	int rc_n = 0;
	int rc0;
	wire [15:0] fcc;
	wire [4:0] sym;
	wire [3:0] rxd;
	int n_errors = 0;
	int n_compared = 0;
	logic [7:0] rnd = 8'h2B;
	logic [4:0] got[$];
	logic [4:0] exp[$];
	logic [4:0] tbl[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic [4:0] bads[3] = '{5'h04, 5'h00, 5'h19};
	logic [15:0] c0;
	logic lost;

	fep_far_line u_far (.line_clk_o(line_clk), .line_data_o(line_data), .scr_en_i(scr));
	fep_rx_pcs_decode #(.LINK_UP_CYCLES(17'h000C8), .HOLD_CYCLES(17'h007D0)) uut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .line_clk_i(line_clk), .line_data_i(line_data),
		.signal_detect_i(signal_detect_i), .desc_bypass_i(desc_bypass_i), .rx_bypass_i(rx_bypass_i),
		.rec_clk_o(rec_clk), .sd_valid_o(sd_valid), .link_up_o(link_up), .pcs_enable_o(), .desc_sync_o(desc_sync),
		.false_carrier_event_counter_o(fcc), .sym_o(sym), .sym_valid_o(sym_valid), .rxd_o(rxd),
		.rx_dv_o(rx_dv), .rx_er_o(rx_er), .crs_o(crs), .nibble_valid_o(nib_valid));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
		if (nib_valid === 1'b1)
			got.push_back({rx_er, rxd});
	// recovered clock rises once per line bit
	always @(posedge ref_clk_i) begin
		rc_prev <= rec_clk;
		if (rec_clk === 1'b1 && rc_prev === 1'b0)
			rc_n++;
	end

	function automatic [7:0] nxt(input [7:0] s);
		nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task chk(input [15:0] s, input [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the tail leaves over 58 idle bits so the hold timer restarts
	task wait_done;
		while (u_far.q.size() != 0) @(negedge ref_clk_i);
		repeat (520) @(negedge ref_clk_i);
	endtask
	task automatic run_pkt(input int n, input [4:0] bad, input bit tr);
		got.delete();
		exp = '{5'h05, 5'h05};
		u_far.q = '{5'h18, 5'h11};
		for (int i = 0; i < n; i++) begin
			rnd = nxt(rnd);
			u_far.q.push_back((i == 1) ? bad : tbl[rnd[3:0]]);
			exp.push_back((i != 1) ? {1'b0, rnd[3:0]} : (bad == 5'h1E) ? 5'h00 : 5'h10);
		end
		if (tr) begin
			u_far.q.push_back(5'h0D);
			u_far.q.push_back(5'h07);
		end
		wait_done();
		chk(got.size(), exp.size());
		foreach (exp[i])
			if (exp[i] == 5'h10)
				chk(got[i][4], 1'b1);
			else
				chk(got[i], exp[i]);
		chk({rx_dv, crs, rx_er}, 3'h0);
	endtask

	initial begin
		#400000;
		n_errors++;
		give_verdict();
	end
	initial begin
		reset_i = 1'b1;
		signal_detect_i = 1'b0;
		desc_bypass_i = 1'b0;
		rx_bypass_i = 1'b0;
		scr = 1'b1;
		repeat (16) @(negedge ref_clk_i);
		reset_i = 1'b0;
		repeat (4) begin
			signal_detect_i = 1'b1;
			repeat (10) @(negedge ref_clk_i);
			signal_detect_i = 1'b0;
			repeat (40) @(negedge ref_clk_i);
			chk(sd_valid, 1'b0);
		end
		signal_detect_i = 1'b1;
		repeat (280) @(negedge ref_clk_i);
		chk(link_up, 1'b0);
		repeat (40) @(negedge ref_clk_i);
		chk(link_up, 1'b1);
		repeat (600) @(negedge ref_clk_i);
		chk(desc_sync, 1'b1);
		// idle alone, longer than the hold time, must keep sync
		rc0 = rc_n;
		repeat (2400) @(negedge ref_clk_i);
		chk(desc_sync, 1'b1);
		chk(rc_n - rc0, 300);
		run_pkt(8, 5'h1E, 1'b1);
		run_pkt(6, 5'h1E, 1'b0);
		foreach (bads[i])
			run_pkt(5, bads[i], 1'b1);
		repeat (2)
			run_pkt(25, 5'h1E, 1'b1);
		chk(desc_sync, 1'b1);
		repeat (2) begin
			c0 = fcc;
			got.delete();
			u_far.q = '{5'h0A, 5'h0B, 5'h0E};
			wait_done();
			chk(got.size() > 1, 1'b1);
			foreach (got[i])
				chk(got[i], 5'h1E);
			chk(fcc, c0 + 16'h0001);
			chk({rx_er, crs}, 2'h0);
		end
		// a packet longer than the hold time with no idle inside
		lost = 1'b0;
		u_far.q = '{5'h18, 5'h11};
		repeat (60)
			u_far.q.push_back(5'h0E);
		while (u_far.q.size() != 0) begin
			@(negedge ref_clk_i);
			lost = lost | ~desc_sync;
		end
		chk(lost, 1'b1);
		repeat (800) @(negedge ref_clk_i);
		chk(desc_sync, 1'b1);
		scr = 1'b0;
		desc_bypass_i = 1'b1;
		// a bit in flight at the switch may start a false carrier; let it clear
		repeat (400) @(negedge ref_clk_i);
		run_pkt(6, 5'h1E, 1'b1);
		rx_bypass_i = 1'b1;
		repeat (100) @(negedge ref_clk_i);
		while (sym_valid !== 1'b1) @(negedge ref_clk_i);
		chk(sym, 5'h1F);
		signal_detect_i = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		chk(link_up, 1'b0);
		give_verdict();
	end
endmodule // test_fast_eth_rx_pcs_decode
